// File: design/opmc_core.sv
// Operating-mode controller: mode sequencing, clock select and gating.
// Assumes gear_clk_en/slow_tick are single-mclk strobes from the clock tree
// and tb_src is an asynchronous level from the time base divider.
`timescale 1ns/1ps

module opmc_core
  import opmc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic gear_clk_en,
  input wire logic slow_tick,
  input wire logic tb_src,
  input wire logic freeze_release,
  input wire logic [7:0] irq_latch,
  input wire logic [7:0] interrupt_enable_register,
  input wire logic interrupt_master_enable,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic main_clk_en,
  output logic main_clk_slow,
  output logic cpu_clk_en,
  output logic wdt_clk_en,
  output logic periph_clk_en,
  output logic tbt_clk_en,
  output logic prescaler_run,
  output logic fast_osc_on,
  output logic slow_osc_on,
  output logic slow_pins_gpio,
  output logic periph_halt_hold,
  output logic time_base_interrupt,
  output logic wake_vector_take
);
  import opmc_pkg::*;

  // -------------------------------------------------------------
  // Registers and state
  // -------------------------------------------------------------
  opmc_mode_t mode_r, mode_nxt, pre_freeze_r;
  logic [7:0] ctrl_one_r;
  logic [7:0] ctrl_two_r;
  logic [7:0] tb_ctrl_r;
  logic [7:0] warmup_r;
  logic [OPMC_WARMUP_STAGES-1:0] wu_cnt_r;
  logic [1:0] slow_div_r;
  logic tb_en_at_entry_r;
  logic tb_s1_r, tb_s2_r, tb_s3_r;
  logic rel_s1_r, rel_s2_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic tb_fall, wake_irq, do_write, in_timer_halt;
  logic req_freeze, req_tg, req_core;

  // Helper: byte-lane merge for an 8-bit register in lane 0 or 1
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s,
                                        input int lane);
    merge8 = s[lane] ? d[lane*8 +: 8] : old;
  endfunction

  // -------------------------------------------------------------
  // Synchronisers: first stage feeds only the second
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tb_s1_r <= 1'b0;
      tb_s2_r <= 1'b0;
      tb_s3_r <= 1'b0;
      rel_s1_r <= 1'b0;
      rel_s2_r <= 1'b0;
    end else if (clk_en) begin
      tb_s1_r <= tb_src;
      tb_s2_r <= tb_s1_r;
      tb_s3_r <= tb_s2_r;
      rel_s1_r <= freeze_release;
      rel_s2_r <= rel_s1_r;
    end
  end

  assign tb_fall = tb_s3_r & ~tb_s2_r;
  assign wake_irq = |(irq_latch & interrupt_enable_register);
  assign in_timer_halt = (mode_r == OPMC_SINGLE_CLOCK_TIMER_ONLY) ||
                         (mode_r == OPMC_SLOW_TIMER_ONLY_HALT);

  // -------------------------------------------------------------
  // AXI4-Lite write channel: address and data in either order
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  // -------------------------------------------------------------
  // Control registers; request bits self-clear once acted on
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_one_r <= 8'h00;
      ctrl_two_r <= OPMC_CTRL_TWO_RESET;
      tb_ctrl_r <= 8'h00;
      warmup_r <= OPMC_WARMUP_RESET;
    end else if (clk_en) begin
      if (mode_r != mode_nxt) begin
        ctrl_one_r[OPMC_FREEZE_POS] <= 1'b0;
        ctrl_two_r[OPMC_CORE_HALT_POS] <= 1'b0;
        ctrl_two_r[OPMC_TG_HALT_POS] <= 1'b0;
      end
      if (do_write) begin
        if (aw_addr_r == OPMC_SYSTEM_CONTROL_ONE) begin
          ctrl_one_r <= merge8(ctrl_one_r, w_data_r, w_strb_r, 0);
        end else if (aw_addr_r == OPMC_SYSTEM_CONTROL_TWO) begin
          ctrl_two_r <= merge8(ctrl_two_r, w_data_r, w_strb_r, 0);
        end else if (aw_addr_r == OPMC_WAKE_CONTROL) begin
          tb_ctrl_r <= merge8(tb_ctrl_r, w_data_r, w_strb_r, 0);
          warmup_r <= merge8(warmup_r, w_data_r, w_strb_r, 1);
        end
      end
    end
  end

  assign req_freeze = ctrl_one_r[OPMC_FREEZE_POS];
  assign req_tg = ctrl_two_r[OPMC_TG_HALT_POS];
  assign req_core = ctrl_two_r[OPMC_CORE_HALT_POS];

  // -------------------------------------------------------------
  // AXI4-Lite read channel, one-cycle answer
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        if (s_axi_araddr[7:0] == OPMC_SYSTEM_CONTROL_ONE) begin
          s_axi_rdata <= {24'h000000, ctrl_one_r};
        end else if (s_axi_araddr[7:0] == OPMC_SYSTEM_CONTROL_TWO) begin
          s_axi_rdata <= {24'h000000, ctrl_two_r};
        end else if (s_axi_araddr[7:0] == OPMC_WAKE_CONTROL) begin
          s_axi_rdata <= {16'h0000, warmup_r, tb_ctrl_r};
        end else if (s_axi_araddr[7:0] == OPMC_MODE_STATUS) begin
          s_axi_rdata <= {22'h000000, mode_r};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;             // Unmapped: slave error
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // -------------------------------------------------------------
  // Mode sequencer
  // -------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      OPMC_SINGLE_CLOCK_RUN, OPMC_DUAL_CLOCK_FAST_RUN,
      OPMC_SLOW_RUN_FAST_OSC_ON, OPMC_SLOW_RUN_FAST_OSC_OFF: begin
        if (req_freeze) begin
          mode_nxt = OPMC_FREEZE;
        end else if (req_tg) begin
          if (mode_r == OPMC_SINGLE_CLOCK_RUN) begin
            mode_nxt = OPMC_SINGLE_CLOCK_TIMER_ONLY;
          end else if (mode_r == OPMC_SLOW_RUN_FAST_OSC_OFF) begin
            mode_nxt = OPMC_SLOW_TIMER_ONLY_HALT;
          end
        end else if (req_core) begin
          if (mode_r == OPMC_SINGLE_CLOCK_RUN) begin
            mode_nxt = OPMC_SINGLE_CLOCK_CORE_HALT;
          end else if (mode_r == OPMC_DUAL_CLOCK_FAST_RUN) begin
            mode_nxt = OPMC_DUAL_CLOCK_FAST_HALT;
          end else if (mode_r == OPMC_SLOW_RUN_FAST_OSC_OFF) begin
            mode_nxt = OPMC_SLOW_CORE_HALT;
          end
        end else if (mode_r == OPMC_SINGLE_CLOCK_RUN) begin
          if (ctrl_two_r[OPMC_SLOW_EN_POS]) begin
            mode_nxt = OPMC_DUAL_CLOCK_FAST_RUN;
          end
        end else if (mode_r == OPMC_DUAL_CLOCK_FAST_RUN) begin
          if (!ctrl_two_r[OPMC_SLOW_EN_POS]) begin
            mode_nxt = OPMC_SINGLE_CLOCK_RUN;
          end else if (ctrl_two_r[OPMC_SYSTEM_CLOCK_SELECT_BIT_POS]) begin
            mode_nxt = OPMC_SLOW_RUN_FAST_OSC_ON;
          end
        end else if (mode_r == OPMC_SLOW_RUN_FAST_OSC_ON) begin
          if (!ctrl_two_r[OPMC_SYSTEM_CLOCK_SELECT_BIT_POS]) begin
            mode_nxt = OPMC_DUAL_CLOCK_FAST_RUN;
          end else if (!ctrl_two_r[OPMC_FAST_EN_POS]) begin
            mode_nxt = OPMC_SLOW_RUN_FAST_OSC_OFF;
          end
        end else begin
          if (ctrl_two_r[OPMC_FAST_EN_POS]) begin
            mode_nxt = OPMC_SLOW_RUN_FAST_OSC_ON;
          end
        end
      end
      OPMC_SINGLE_CLOCK_CORE_HALT: begin
        if (wake_irq) mode_nxt = OPMC_SINGLE_CLOCK_RUN;
      end
      OPMC_DUAL_CLOCK_FAST_HALT: begin
        if (wake_irq) mode_nxt = OPMC_DUAL_CLOCK_FAST_RUN;
      end
      OPMC_SLOW_CORE_HALT: begin
        if (wake_irq) mode_nxt = OPMC_SLOW_RUN_FAST_OSC_OFF;
      end
      OPMC_SINGLE_CLOCK_TIMER_ONLY: begin
        if (tb_fall) mode_nxt = OPMC_SINGLE_CLOCK_RUN;
      end
      OPMC_SLOW_TIMER_ONLY_HALT: begin
        if (tb_fall) mode_nxt = OPMC_SLOW_RUN_FAST_OSC_OFF;
      end
      OPMC_FREEZE: begin
        if (wu_cnt_r[OPMC_WARMUP_STAGES-1 -: OPMC_WARMUP_CMP_W] == warmup_r
            && wu_cnt_r != '0) begin
          mode_nxt = pre_freeze_r;
        end
      end
      default: mode_nxt = OPMC_SINGLE_CLOCK_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= OPMC_SINGLE_CLOCK_RUN;
      pre_freeze_r <= OPMC_SINGLE_CLOCK_RUN;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
      if (mode_nxt == OPMC_FREEZE && mode_r != OPMC_FREEZE) begin
        pre_freeze_r <= mode_r;
      end
    end
  end

  // -------------------------------------------------------------
  // Warm-up counter: starts on release, counts every mclk cycle with clk_en high
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wu_cnt_r <= '0;
    end else if (clk_en) begin
      if (mode_r != OPMC_FREEZE) begin
        wu_cnt_r <= '0;
      end else if (wu_cnt_r != '0 || rel_s2_r) begin
        wu_cnt_r <= wu_cnt_r + OPMC_WARMUP_STAGES'(1);
      end
    end
  end

  // -------------------------------------------------------------
  // Quarter-rate slow clock and wake bookkeeping
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slow_div_r <= 2'b00;
      tb_en_at_entry_r <= 1'b0;
      time_base_interrupt <= 1'b0;
      wake_vector_take <= 1'b0;
    end else if (clk_en) begin
      if (slow_tick) slow_div_r <= slow_div_r + 2'd1;
      if (!in_timer_halt && (mode_nxt == OPMC_SINGLE_CLOCK_TIMER_ONLY ||
                             mode_nxt == OPMC_SLOW_TIMER_ONLY_HALT)) begin
        tb_en_at_entry_r <= tb_ctrl_r[OPMC_TB_EN_POS];
      end
      time_base_interrupt <= in_timer_halt && tb_fall &&
                             tb_en_at_entry_r;
      // One-cycle strobe: vector to handler or fall through
      wake_vector_take <= (wake_irq && interrupt_master_enable &&
                           (mode_r == OPMC_SINGLE_CLOCK_CORE_HALT ||
                            mode_r == OPMC_DUAL_CLOCK_FAST_HALT ||
                            mode_r == OPMC_SLOW_CORE_HALT))
                       || (in_timer_halt && tb_fall && tb_en_at_entry_r &&
                           interrupt_master_enable &&
                           interrupt_enable_register[5]);
    end
  end

  // -------------------------------------------------------------
  // Clock gates, registered so every output leaves a flop
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      main_clk_en <= 1'b0;
      main_clk_slow <= 1'b0;
      cpu_clk_en <= 1'b0;
      wdt_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      tbt_clk_en <= 1'b0;
      prescaler_run <= 1'b1;
      fast_osc_on <= 1'b1;
      slow_osc_on <= 1'b0;
      slow_pins_gpio <= 1'b1;
      periph_halt_hold <= 1'b0;
    end else if (clk_en) begin
      main_clk_slow <= mode_nxt[5] | mode_nxt[6] | mode_nxt[7] |
                       mode_nxt[8];
      main_clk_en <= (mode_nxt[5] | mode_nxt[6] | mode_nxt[7] | mode_nxt[8])
                     ? (slow_tick && slow_div_r == 2'(OPMC_SLOW_DIV-1))
                     : (gear_clk_en && mode_nxt != OPMC_FREEZE);
      cpu_clk_en <= mode_nxt[0] | mode_nxt[3] | mode_nxt[5] |
                    mode_nxt[6];
      wdt_clk_en <= mode_nxt[0] | mode_nxt[3] | mode_nxt[5] |
                    mode_nxt[6];
      periph_clk_en <= mode_nxt[0] | mode_nxt[1] | mode_nxt[3] | mode_nxt[4]
                       | mode_nxt[5] | mode_nxt[6] | mode_nxt[7];
      tbt_clk_en <= mode_nxt != OPMC_FREEZE;
      prescaler_run <= !(mode_nxt[5] | mode_nxt[6] | mode_nxt[7]) &&
                       mode_nxt != OPMC_FREEZE;
      fast_osc_on <= mode_nxt[0] | mode_nxt[1] | mode_nxt[2] | mode_nxt[3] |
                     mode_nxt[4] | mode_nxt[5];
      slow_osc_on <= !(mode_nxt[0] | mode_nxt[1] | mode_nxt[2]) &&
                     mode_nxt != OPMC_FREEZE;
      slow_pins_gpio <= mode_nxt[0] | mode_nxt[1] | mode_nxt[2];
      periph_halt_hold <= mode_nxt[2] | mode_nxt[8] | mode_nxt[9];
    end
  end

endmodule // opmc_core

// File: inc/opmc_pkg.sv
// Constants, register map and mode encodings of the operating-mode controller.
// Assumes a 32-bit AXI4-Lite master and a 100 MHz mclk.
package opmc_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OPMC_SYSTEM_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OPMC_SYSTEM_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OPMC_WAKE_CONTROL = 8'h08;
  localparam logic [7:0] OPMC_MODE_STATUS = 8'h0C;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int OPMC_FREEZE_POS = 7;       // system_control_one
  localparam int OPMC_CORE_HALT_POS = 4;    // system_control_two
  localparam int OPMC_TG_HALT_POS = 2;      // timing_gen_halt_bit
  localparam int OPMC_SYSTEM_CLOCK_SELECT_BIT_POS = 5;        // system_clock_select_bit
  localparam int OPMC_FAST_EN_POS = 7;      // fast_osc_enable_bit
  localparam int OPMC_SLOW_EN_POS = 6;      // slow oscillator enable
  localparam int OPMC_TB_SRC_LSB = 0;       // time_base_source_select
  localparam int OPMC_TB_SRC_W = 3;
  localparam int OPMC_TB_EN_POS = 3;        // time_base_enable_bit
  localparam int OPMC_WARMUP_LSB = 8;       // warmup_compare_value
  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] OPMC_WARMUP_RESET = 8'h66;
  localparam logic [7:0] OPMC_CTRL_TWO_RESET = 8'h80;
  localparam int OPMC_WARMUP_STAGES = 14;
  localparam int OPMC_WARMUP_CMP_W = 8;
  localparam int OPMC_SLOW_DIV = 4;
  // ---------------------------------------------------------------
  // Operating modes, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [9:0] {
    OPMC_SINGLE_CLOCK_RUN       = 10'h001,
    OPMC_SINGLE_CLOCK_CORE_HALT = 10'h002,
    OPMC_SINGLE_CLOCK_TIMER_ONLY= 10'h004,
    OPMC_DUAL_CLOCK_FAST_RUN    = 10'h008,
    OPMC_DUAL_CLOCK_FAST_HALT   = 10'h010,
    OPMC_SLOW_RUN_FAST_OSC_ON   = 10'h020,
    OPMC_SLOW_RUN_FAST_OSC_OFF  = 10'h040,
    OPMC_SLOW_CORE_HALT         = 10'h080,
    OPMC_SLOW_TIMER_ONLY_HALT   = 10'h100,
    OPMC_FREEZE                 = 10'h200
  } opmc_mode_t;
endpackage

// File: verification/opmc_core_sva.sv
// Checker for the operating-mode controller gate and clock outputs.
// Assumes it is bound to opmc_core and sees only its ports.
`timescale 1ns/1ps
module opmc_core_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] irq_latch,
  input wire logic [7:0] interrupt_enable_register,
  input wire logic interrupt_master_enable,
  input wire logic main_clk_en,
  input wire logic main_clk_slow,
  input wire logic cpu_clk_en,
  input wire logic wdt_clk_en,
  input wire logic periph_clk_en,
  input wire logic tbt_clk_en,
  input wire logic prescaler_run,
  input wire logic fast_osc_on,
  input wire logic slow_osc_on,
  input wire logic slow_pins_gpio,
  input wire logic wake_vector_take
);
  // ---------------------------
  // Mode and gate relations
  // ---------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Core halted, clocks enabled, enabled latch pending; a low clk_en freezes
  sequence s_halt_wake;
    clk_en && !cpu_clk_en && periph_clk_en &&
      (|(irq_latch & interrupt_enable_register));
  endsequence
  a_single_gear_clk: assert property (
    slow_pins_gpio |-> !main_clk_slow) else $error("slow clock in single");
  a_pins_osc_busy: assert property (
    slow_osc_on |-> !slow_pins_gpio) else $error("pins free in dual");
  a_halt_stops_wdt: assert property (
    !cpu_clk_en && periph_clk_en |-> !wdt_clk_en) else $error("wdt runs");
  a_irq_wake_next: assert property (
    s_halt_wake |=> cpu_clk_en) else $error("no wake on irq");
  a_vector_needs_ime: assert property (
    wake_vector_take |-> $past(interrupt_master_enable))
    else $error("vector without master enable");
  a_timer_halt_cpu: assert property (
    tbt_clk_en && !periph_clk_en |-> !cpu_clk_en && !wdt_clk_en)
    else $error("cpu runs in timer halt");
  a_slow_no_prescale: assert property (
    main_clk_slow && cpu_clk_en |-> !prescaler_run)
    else $error("prescaler runs slow");
  a_freeze_all_off: assert property (
    !fast_osc_on && !slow_osc_on |-> !(cpu_clk_en || periph_clk_en ||
    tbt_clk_en || main_clk_en)) else $error("clock runs in freeze");
endmodule // opmc_core_sva

bind opmc_core opmc_core_sva chk_u (.mclk, .reset_n, .clk_en, .irq_latch,
  .interrupt_enable_register, .interrupt_master_enable, .main_clk_en,
  .main_clk_slow, .cpu_clk_en, .wdt_clk_en, .periph_clk_en, .tbt_clk_en,
  .prescaler_run, .fast_osc_on, .slow_osc_on, .slow_pins_gpio,
  .wake_vector_take);

// File: verification/opmc_cpu_model.sv
// CPU-side model: interrupt latches and enable flags.
// Assumes the bench calls its tasks; changes follow mclk rising edges.
`timescale 1ns/1ps
module opmc_cpu_model (
  input wire logic mclk,
  output logic [7:0] irq_latch,
  output logic [7:0] interrupt_enable_register,
  output logic interrupt_master_enable
);
  // -----------------------
  // Interrupt flag driving
  // -----------------------
  // Quiet until software sets interrupts up
  initial begin
    irq_latch = 8'h00;
    interrupt_enable_register = 8'h00;
    interrupt_master_enable = 1'b0;
  end
  // Raise or drop pending latches
  task irq(input logic [7:0] l);
    @(posedge mclk);
    irq_latch <= l;
  endtask
  // Only an enabled latch may end a core halt
  task en(input logic [7:0] e, input logic m);
    @(posedge mclk);
    interrupt_enable_register <= e;
    interrupt_master_enable <= m;
  endtask
endmodule // opmc_cpu_model

// File: verification/tb_operating_mode_controller.sv
// Bench for the operating-mode controller: AXI4-Lite mode walk.
// Assumes opmc_core, the CPU model and the bound checker are compiled.
`timescale 1ns/1ps
module tb_operating_mode_controller;
  import opmc_pkg::*;
  logic reset_n, clk_en, tb_src;
  logic mclk = 1'b0, gear_clk_en = 1'b0, slow_tick = 1'b0;
  logic freeze_release, interrupt_master_enable, main_clk_en;
  logic main_clk_slow, cpu_clk_en, wdt_clk_en, periph_clk_en, tbt_clk_en;
  logic prescaler_run, fast_osc_on, slow_osc_on, slow_pins_gpio;
  logic periph_halt_hold, time_base_interrupt, wake_vector_take;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [3:0] s_axi_wstrb;
  logic [7:0] irq_latch, interrupt_enable_register;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_data;
  int err_count, comparisons, n_vec = 0, n_tbi = 0, tick = 0, n_mck = 0;
  // ----------------------
  // Device and CPU side
  // ----------------------
  opmc_core dut_u (.mclk, .reset_n, .clk_en, .gear_clk_en, .slow_tick,
    .tb_src, .freeze_release, .irq_latch, .interrupt_enable_register,
    .interrupt_master_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .main_clk_en, .main_clk_slow, .cpu_clk_en, .wdt_clk_en, .periph_clk_en,
    .tbt_clk_en, .prescaler_run, .fast_osc_on, .slow_osc_on, .slow_pins_gpio,
    .periph_halt_hold, .time_base_interrupt, .wake_vector_take);
  opmc_cpu_model cpu_u (.mclk, .irq_latch, .interrupt_enable_register,
    .interrupt_master_enable);
  // Free-running clock
  always #5 mclk = ~mclk;
  // Gear strobe every 2nd edge, slow tick every 8th; pulse counts
  always @(posedge mclk) begin
    tick <= tick + 1;
    gear_clk_en <= (tick % 2 == 0);
    slow_tick <= (tick % 8 == 0);
    n_vec <= n_vec + int'(wake_vector_take === 1'b1);
    n_tbi <= n_tbi + int'(time_base_interrupt === 1'b1);
    n_mck <= n_mck + int'(main_clk_en === 1'b1);
  end
  // Verdict and end of run
  task results();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hung wait counts as a mismatch
  task hang();
    err_count++;
    results();
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // One AXI4-Lite write or read; holds each channel until taken
  task xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    if (w) begin
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      s_axi_araddr <= {24'h0, a};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    rd_data = s_axi_rdata;
    rd_resp = w ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n == 200) hang();
  endtask
  task mode(input opmc_mode_t m);
    xfer(1'b0, OPMC_MODE_STATUS, 32'h0);
    chk("mode", {22'h0, m}, rd_data);
  endtask
  task step(input logic [7:0] v, input opmc_mode_t m);
    xfer(1'b1, OPMC_SYSTEM_CONTROL_TWO, {24'h0, v});
    mode(m);
  endtask
  // Main clock ticks over a window; independent of strobe phase
  task mck(input int c, input int e);
    int n0;
    n0 = n_mck;
    repeat (c) @(posedge mclk);
    chk("main clk ticks", e, n_mck - n0);
  endtask
  // Wake by enabled latch (k=0) or time-base falling edge (k=1)
  task wake(input bit k, input opmc_mode_t m);
    int n;
    if (k) tb_src <= 1'b1;
    else cpu_u.irq(8'h01);
    repeat (4) @(posedge mclk);
    tb_src <= 1'b0;
    for (n = 0; n < 3000 && cpu_clk_en !== 1'b1; n++) @(posedge mclk);
    cpu_u.irq(8'h00);
    if (n == 3000) hang();
    mode(m);
  endtask
  // -----------------
  // Mode walk
  // -----------------
  initial begin
    {reset_n, tb_src, freeze_release} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
    {err_count, comparisons} = 0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("run gates", {28'h0, cpu_clk_en, periph_clk_en, tbt_clk_en,
      slow_pins_gpio}, 32'hF);
    xfer(1'b0, OPMC_SYSTEM_CONTROL_TWO, 32'h0);
    chk("ctrl two", {24'h0, OPMC_CTRL_TWO_RESET}, rd_data);
    xfer(1'b0, OPMC_WAKE_CONTROL, 32'h0);
    chk("warmup", {16'h0, OPMC_WARMUP_RESET, 8'h00}, rd_data);
    mode(OPMC_SINGLE_CLOCK_RUN);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h2, {30'h0, rd_resp});
    cpu_u.en(8'h01, 1'b0);
    step(8'h90, OPMC_SINGLE_CLOCK_CORE_HALT);
    chk("halt gates", {29'h0, cpu_clk_en, wdt_clk_en, periph_clk_en},
      32'h1);
    // Low clock enable must hold the halt although a wake is pending
    clk_en <= 1'b0;
    cpu_u.irq(8'h01);
    repeat (4) @(posedge mclk);
    chk("frozen", 32'h0, {31'h0, cpu_clk_en});
    clk_en <= 1'b1;
    wake(1'b0, OPMC_SINGLE_CLOCK_RUN);
    chk("no vector", 32'h0, n_vec);
    xfer(1'b1, OPMC_WAKE_CONTROL, 32'h0000_0208);
    chk("bresp", 32'h0, {30'h0, rd_resp});
    cpu_u.en(8'h20, 1'b1);
    step(8'h84, OPMC_SINGLE_CLOCK_TIMER_ONLY);
    chk("tmr gates", {28'h0, cpu_clk_en, periph_clk_en, tbt_clk_en,
      periph_halt_hold}, 32'h3);
    wake(1'b1, OPMC_SINGLE_CLOCK_RUN);
    chk("tb irq", 32'h1, n_tbi);
    chk("tb vector", 32'h1, n_vec);
    step(8'h94, OPMC_SINGLE_CLOCK_TIMER_ONLY);
    wake(1'b1, OPMC_SINGLE_CLOCK_RUN);
    xfer(1'b1, OPMC_SYSTEM_CONTROL_ONE, 32'h80);
    mode(OPMC_FREEZE);
    chk("freeze osc", {29'h0, fast_osc_on, slow_osc_on, periph_halt_hold},
      32'h1);
    freeze_release <= 1'b1;
    wake(1'b1, OPMC_SINGLE_CLOCK_RUN);
    freeze_release <= 1'b0;
    cpu_u.en(8'h01, 1'b1);
    step(8'hC0, OPMC_DUAL_CLOCK_FAST_RUN);
    chk("pins", {31'h0, slow_pins_gpio}, 32'h0);
    mck(16, 8);
    step(8'hD0, OPMC_DUAL_CLOCK_FAST_HALT);
    wake(1'b0, OPMC_DUAL_CLOCK_FAST_RUN);
    step(8'hE0, OPMC_SLOW_RUN_FAST_OSC_ON);
    chk("slow clk", {30'h0, main_clk_slow, prescaler_run}, 32'h2);
    mck(64, 2);
    step(8'h60, OPMC_SLOW_RUN_FAST_OSC_OFF);
    chk("fast osc", {31'h0, fast_osc_on}, 32'h0);
    step(8'h70, OPMC_SLOW_CORE_HALT);
    wake(1'b0, OPMC_SLOW_RUN_FAST_OSC_OFF);
    step(8'h64, OPMC_SLOW_TIMER_ONLY_HALT);
    wake(1'b1, OPMC_SLOW_RUN_FAST_OSC_OFF);
    step(8'hE0, OPMC_SLOW_RUN_FAST_OSC_ON);
    step(8'hC0, OPMC_DUAL_CLOCK_FAST_RUN);
    step(8'h80, OPMC_SINGLE_CLOCK_RUN);
    mck(16, 8);
    results();
  end
endmodule // tb_operating_mode_controller
